// ==== core/gcc_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module gcc_regs #(
  parameter int NUM_OUT = 10,           // output clocks
  parameter int NUM_PIN = 4             // general-purpose pins
) (
  input  wire logic                    core_clk_in,          // register clock
  input  wire logic                    srst_in,              // sync reset, high
  input  wire logic [9:0]              addr_in,              // register address
  input  wire logic                    wr_en_in,             // write strobe
  input  wire logic [7:0]              wr_data_in,           // write data
  input  wire logic                    rd_en_in,             // read strobe
  output logic      [7:0]              rd_data_out,          // read data
  input  wire logic [NUM_OUT-1:0][3:0] stop_source_in,       // per-output stop source
  input  wire logic [NUM_PIN-1:0][7:0] pin_status_select_in, // per-pin status select
  input  wire logic [255:0]            status_vec_in,        // status regs from 0x40
  input  wire logic [255:0]            status_impl_in,       // implemented status bits
  input  wire logic [NUM_PIN-1:0]      pin_level_in,         // raw pin levels
  output logic      [NUM_PIN-1:0]      pin_drive_out,        // pin output level
  output logic      [NUM_PIN-1:0]      pin_oe_n_out,         // pin enable, low drives
  output logic      [NUM_PIN-1:0]      pin_in_data_out,      // pin input value
  output logic                         xtal_drv_en_out,      // crystal driver on
  output logic                         osc_in_en_out,        // oscillator input on
  output logic                         pll_enable_out,       // synth pll on
  output logic      [2:0]              input_enable_out,     // inputs 3..1
  output logic      [NUM_OUT-1:0]      output_enable_out,    // outputs 10..1
  output var gcc_pkg::gcc_src_t        group_source_out,     // group sources
  output logic      [NUM_OUT-1:0]      output_stop_out       // outputs stopped
);

  logic [7:0] master_reg, xtal_mode_reg, pll_en_reg, in_en_reg;
  logic [7:0] out_en_lo_reg, out_en_hi_reg, src_1_reg, src_2_reg;
  logic [7:0] stop_1_reg, stop_2_reg, pcfg_01_reg, pcfg_23_reg;
  logic [NUM_PIN-1:0] pin_meta_reg, pin_sync_reg;

  // writable bits of each address; zero for anything unmapped
  function automatic logic [7:0] reg_mask(input logic [9:0] a);
    case (a)
      gcc_pkg::ADDR_MASTER:    reg_mask = gcc_pkg::MASK_MASTER;
      gcc_pkg::ADDR_XTAL_MODE: reg_mask = gcc_pkg::MASK_XTAL_MODE;
      gcc_pkg::ADDR_PLL_EN:    reg_mask = gcc_pkg::MASK_PLL_EN;
      gcc_pkg::ADDR_IN_EN:     reg_mask = gcc_pkg::MASK_IN_EN;
      gcc_pkg::ADDR_OUT_EN_LO: reg_mask = gcc_pkg::MASK_OUT_EN_LO;
      gcc_pkg::ADDR_OUT_EN_HI: reg_mask = gcc_pkg::MASK_OUT_EN_HI;
      gcc_pkg::ADDR_SRC_1:     reg_mask = gcc_pkg::MASK_SRC;
      gcc_pkg::ADDR_SRC_2:     reg_mask = gcc_pkg::MASK_SRC;
      gcc_pkg::ADDR_STOP_1:    reg_mask = gcc_pkg::MASK_STOP_1;
      gcc_pkg::ADDR_STOP_2:    reg_mask = gcc_pkg::MASK_STOP_2;
      gcc_pkg::ADDR_PCFG_01:   reg_mask = gcc_pkg::MASK_PCFG;
      gcc_pkg::ADDR_PCFG_23:   reg_mask = gcc_pkg::MASK_PCFG;
      default:                 reg_mask = 8'h00;
    endcase
  endfunction

  // next value of one register: masked write data on a hit
  // the request is an argument so each wire follows every bus change
  function automatic logic [7:0] reg_upd(input logic [18:0] req, input logic [9:0] a,
                                         input logic [7:0] cur);
    reg_upd = (req[18] && req[17:8] == a) ? (req[7:0] & reg_mask(a)) : cur;
  endfunction

  // status bit a pin follows, with forbidden and absent bits forced low
  function automatic logic status_pick(input logic [7:0] sel, input logic [255:0] vec,
                                       input logic [255:0] impl);
    logic excluded;
    excluded = (sel[7:3] == gcc_pkg::ST_IDX_PIN_STATUS) ||
               (sel[7:3] == gcc_pkg::ST_IDX_PLL_IRQ_EN);
    status_pick = vec[sel] & impl[sel] & ~excluded;
  endfunction

  // write request bundle: strobe, address, data
  wire logic [18:0] wr_req = {wr_en_in, addr_in, wr_data_in};

  // write decode with unused bits dropped
  wire logic [7:0] master_next    = reg_upd(wr_req, gcc_pkg::ADDR_MASTER, master_reg);
  wire logic [7:0] xtal_mode_next = reg_upd(wr_req, gcc_pkg::ADDR_XTAL_MODE, xtal_mode_reg);
  wire logic [7:0] pll_en_next    = reg_upd(wr_req, gcc_pkg::ADDR_PLL_EN, pll_en_reg);
  wire logic [7:0] in_en_next     = reg_upd(wr_req, gcc_pkg::ADDR_IN_EN, in_en_reg);
  wire logic [7:0] out_en_lo_next = reg_upd(wr_req, gcc_pkg::ADDR_OUT_EN_LO, out_en_lo_reg);
  wire logic [7:0] out_en_hi_next = reg_upd(wr_req, gcc_pkg::ADDR_OUT_EN_HI, out_en_hi_reg);
  wire logic [7:0] src_1_next     = reg_upd(wr_req, gcc_pkg::ADDR_SRC_1, src_1_reg);
  wire logic [7:0] src_2_next     = reg_upd(wr_req, gcc_pkg::ADDR_SRC_2, src_2_reg);
  wire logic [7:0] stop_1_next    = reg_upd(wr_req, gcc_pkg::ADDR_STOP_1, stop_1_reg);
  wire logic [7:0] stop_2_next    = reg_upd(wr_req, gcc_pkg::ADDR_STOP_2, stop_2_reg);
  wire logic [7:0] pcfg_01_next   = reg_upd(wr_req, gcc_pkg::ADDR_PCFG_01, pcfg_01_reg);
  wire logic [7:0] pcfg_23_next   = reg_upd(wr_req, gcc_pkg::ADDR_PCFG_23, pcfg_23_reg);

  // configuration registers, all zero after reset
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      master_reg    <= gcc_pkg::RST_VAL;
      xtal_mode_reg <= gcc_pkg::RST_VAL;
      pll_en_reg    <= gcc_pkg::RST_VAL;
      in_en_reg     <= gcc_pkg::RST_VAL;
      out_en_lo_reg <= gcc_pkg::RST_VAL;
      out_en_hi_reg <= gcc_pkg::RST_VAL;
      src_1_reg     <= gcc_pkg::RST_VAL;
      src_2_reg     <= gcc_pkg::RST_VAL;
      stop_1_reg    <= gcc_pkg::RST_VAL;
      stop_2_reg    <= gcc_pkg::RST_VAL;
      pcfg_01_reg   <= gcc_pkg::RST_VAL;
      pcfg_23_reg   <= gcc_pkg::RST_VAL;
    end
    else
    begin
      master_reg    <= master_next;
      xtal_mode_reg <= xtal_mode_next;
      pll_en_reg    <= pll_en_next;
      in_en_reg     <= in_en_next;
      out_en_lo_reg <= out_en_lo_next;
      out_en_hi_reg <= out_en_hi_next;
      src_1_reg     <= src_1_next;
      src_2_reg     <= src_2_next;
      stop_1_reg    <= stop_1_next;
      stop_2_reg    <= stop_2_next;
      pcfg_01_reg   <= pcfg_01_next;
      pcfg_23_reg   <= pcfg_23_next;
    end
  end

  // two-stage synchroniser for the pin levels
  always_ff @(posedge core_clk_in)
  begin
    pin_meta_reg <= pin_level_in;
    pin_sync_reg <= pin_meta_reg;
  end

  // read mux; pin status shows live levels whatever the mode
  wire logic [7:0] pin_status_val = {{(8-NUM_PIN){1'b0}}, pin_sync_reg};
  wire logic [7:0] rd_mux =
    (addr_in == gcc_pkg::ADDR_PIN_STATUS) ? pin_status_val :
    (addr_in == gcc_pkg::ADDR_MASTER)     ? master_reg :
    (addr_in == gcc_pkg::ADDR_XTAL_MODE)  ? xtal_mode_reg :
    (addr_in == gcc_pkg::ADDR_PLL_EN)     ? pll_en_reg :
    (addr_in == gcc_pkg::ADDR_IN_EN)      ? in_en_reg :
    (addr_in == gcc_pkg::ADDR_OUT_EN_LO)  ? out_en_lo_reg :
    (addr_in == gcc_pkg::ADDR_OUT_EN_HI)  ? out_en_hi_reg :
    (addr_in == gcc_pkg::ADDR_SRC_1)      ? src_1_reg :
    (addr_in == gcc_pkg::ADDR_SRC_2)      ? src_2_reg :
    (addr_in == gcc_pkg::ADDR_STOP_1)     ? stop_1_reg :
    (addr_in == gcc_pkg::ADDR_STOP_2)     ? stop_2_reg :
    (addr_in == gcc_pkg::ADDR_PCFG_01)    ? pcfg_01_reg :
    (addr_in == gcc_pkg::ADDR_PCFG_23)    ? pcfg_23_reg : 8'h00;

  // control decode from the stored fields
  wire logic [1:0] xtal_mode = xtal_mode_reg[1:0];
  wire logic xtal_drv_next = (xtal_mode == gcc_pkg::XTAL_DRV);
  wire logic osc_in_next   = (xtal_mode == gcc_pkg::XTAL_DRV) ||
                             (xtal_mode == gcc_pkg::XTAL_EXT);
  wire logic [NUM_OUT-1:0] out_en_all = {out_en_hi_reg[1:0], out_en_lo_reg};
  wire logic [NUM_OUT-1:0] stop_bits  = {stop_2_reg[1:0], stop_1_reg};
  wire logic global_stop = master_reg[gcc_pkg::GLOBAL_STOP_BIT];
  wire logic [15:0] pcfg_all = {pcfg_23_reg, pcfg_01_reg};

  // group source fields, forwarded with the unused code as given
  wire gcc_pkg::gcc_src_t src_next = '{f: src_2_reg[5:4], e: src_2_reg[3:2],
                                       d: src_2_reg[1:0], c: src_1_reg[5:4],
                                       b: src_1_reg[3:2], a: src_1_reg[1:0]};

  // per-output stop: local bit or global stop, only with register source
  logic [NUM_OUT-1:0] stop_next;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_stop
      assign stop_next[gi] = (stop_source_in[gi] == gcc_pkg::STOP_SRC_REG) &&
                             (stop_bits[gi] || global_stop);
    end
  endgenerate

  // pin drivers, each following its own status selection
  gcc_pkg::gcc_pin_t [NUM_PIN-1:0] pin_dec;
  generate
    for (gi = 0; gi < NUM_PIN; gi++)
    begin : g_pin
      wire logic pin_status = status_pick(pin_status_select_in[gi], status_vec_in,
                                          status_impl_in);
      gcc_pin_drive u_pin (
        .cfg_in    (pcfg_all[gi*4 +: 4]),
        .status_in (pin_status),
        .level_in  (pin_sync_reg[gi]),
        .pin_out   (pin_dec[gi])
      );
    end
  endgenerate

  // output flops
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      rd_data_out       <= 8'h00;
      xtal_drv_en_out   <= 1'b0;
      osc_in_en_out     <= 1'b0;
      pll_enable_out    <= 1'b0;
      input_enable_out  <= 3'h0;
      output_enable_out <= '0;
      group_source_out  <= '0;
      output_stop_out   <= '0;
      pin_drive_out     <= '0;
      pin_oe_n_out      <= '1;
      pin_in_data_out   <= '0;
    end
    else
    begin
      if (rd_en_in)
        rd_data_out <= rd_mux;
      xtal_drv_en_out   <= xtal_drv_next;
      osc_in_en_out     <= osc_in_next;
      pll_enable_out    <= pll_en_reg[gcc_pkg::PLL_EN_BIT];
      input_enable_out  <= in_en_reg[2:0];
      output_enable_out <= out_en_all;
      group_source_out  <= src_next;
      output_stop_out   <= stop_next;
      for (int i = 0; i < NUM_PIN; i++)
      begin
        pin_drive_out[i]   <= pin_dec[i].drive;
        pin_oe_n_out[i]    <= pin_dec[i].oe_n;
        pin_in_data_out[i] <= pin_dec[i].in_value;
      end
    end
  end

  property p_xtal_ext;
    @(posedge core_clk_in) disable iff (srst_in)
    xtal_mode_reg[1:0] == gcc_pkg::XTAL_EXT |=> osc_in_en_out && !xtal_drv_en_out;
  endproperty
  a_xtal_ext: assert property (p_xtal_ext) else $error("external osc mode wrong");

  property p_xtal_off;
    @(posedge core_clk_in) disable iff (srst_in)
    xtal_mode_reg[1:0] == gcc_pkg::XTAL_OFF |=> !osc_in_en_out && !xtal_drv_en_out;
  endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("crystal off mode wrong");

  property p_pll;
    @(posedge core_clk_in) disable iff (srst_in)
    wr_en_in && addr_in == gcc_pkg::ADDR_PLL_EN ##1 !srst_in
      |=> pll_enable_out == $past(wr_data_in[0], 2);
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable not applied");

  property p_in_en;
    @(posedge core_clk_in) disable iff (srst_in)
    wr_en_in && addr_in == gcc_pkg::ADDR_IN_EN
      |-> ##2 input_enable_out == $past(wr_data_in[2:0], 2);
  endproperty
  a_in_en: assert property (p_in_en) else $error("input enable not applied");

  property p_out_hi;
    @(posedge core_clk_in) disable iff (srst_in)
    wr_en_in && addr_in == gcc_pkg::ADDR_OUT_EN_HI
      |-> ##2 output_enable_out[9:8] == $past(wr_data_in[1:0], 2);
  endproperty
  a_out_hi: assert property (p_out_hi) else $error("outputs 9 and 10 enable wrong");

  property p_src_f;
    @(posedge core_clk_in) disable iff (srst_in)
    wr_en_in && addr_in == gcc_pkg::ADDR_SRC_2
      |-> ##2 group_source_out.f == $past(wr_data_in[5:4], 2);
  endproperty
  a_src_f: assert property (p_src_f) else $error("group f source wrong");

  property p_stop;
    @(posedge core_clk_in) disable iff (srst_in)
    stop_source_in[0] == gcc_pkg::STOP_SRC_REG && master_reg[5] |=> output_stop_out[0];
  endproperty
  a_stop: assert property (p_stop) else $error("global stop ignored");

  property p_mask;
    @(posedge core_clk_in) disable iff (srst_in)
    rd_en_in && addr_in == gcc_pkg::ADDR_PLL_EN |=> rd_data_out[7:1] == 7'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("unused bits read nonzero");

  property p_reset;
    @(posedge core_clk_in) disable iff (srst_in)
    $fell(srst_in) |-> output_enable_out == '0 && !pll_enable_out && pin_oe_n_out == '1;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");

  property p_pin_low;
    @(posedge core_clk_in) disable iff (srst_in)
    pcfg_01_reg[3:0] == gcc_pkg::PIN_OUT_LOW |=> !pin_oe_n_out[0] && !pin_drive_out[0];
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin 0 not driving low");

  property p_no_self;
    @(posedge core_clk_in) disable iff (srst_in)
    pcfg_01_reg[3:0] == gcc_pkg::PIN_ST &&
      pin_status_select_in[0][7:3] == gcc_pkg::ST_IDX_PIN_STATUS |=> !pin_drive_out[0];
  endproperty
  a_no_self: assert property (p_no_self) else $error("pin status reg followed");

endmodule
`default_nettype wire

// ==== core/gcc_pkg.sv ====
package gcc_pkg;

  // register addresses on the internal register port
  localparam logic [9:0] ADDR_MASTER     = 10'h001;
  localparam logic [9:0] ADDR_XTAL_MODE  = 10'h002;
  localparam logic [9:0] ADDR_PLL_EN     = 10'h003;
  localparam logic [9:0] ADDR_IN_EN      = 10'h004;
  localparam logic [9:0] ADDR_OUT_EN_LO  = 10'h005;
  localparam logic [9:0] ADDR_OUT_EN_HI  = 10'h006;
  localparam logic [9:0] ADDR_SRC_1      = 10'h007;
  localparam logic [9:0] ADDR_SRC_2      = 10'h008;
  localparam logic [9:0] ADDR_STOP_1     = 10'h009;
  localparam logic [9:0] ADDR_STOP_2     = 10'h00a;
  localparam logic [9:0] ADDR_PCFG_01    = 10'h00b;
  localparam logic [9:0] ADDR_PCFG_23    = 10'h00c;
  localparam logic [9:0] ADDR_PIN_STATUS = 10'h041;

  // implemented bits of each register; all others read zero
  localparam logic [7:0] MASK_MASTER    = 8'h20;
  localparam logic [7:0] MASK_XTAL_MODE = 8'h03;
  localparam logic [7:0] MASK_PLL_EN    = 8'h01;
  localparam logic [7:0] MASK_IN_EN     = 8'h07;
  localparam logic [7:0] MASK_OUT_EN_LO = 8'hff;
  localparam logic [7:0] MASK_OUT_EN_HI = 8'h03;
  localparam logic [7:0] MASK_SRC       = 8'h3f;
  localparam logic [7:0] MASK_STOP_1    = 8'hff;
  localparam logic [7:0] MASK_STOP_2    = 8'h03;
  localparam logic [7:0] MASK_PCFG      = 8'hff;
  localparam logic [7:0] RST_VAL        = 8'h00;

  // field positions
  localparam int GLOBAL_STOP_BIT = 5;
  localparam int PLL_EN_BIT      = 0;

  // crystal pin modes
  localparam logic [1:0] XTAL_OFF = 2'h0;
  localparam logic [1:0] XTAL_DRV = 2'h1;
  localparam logic [1:0] XTAL_EXT = 2'h2;

  // output group source codes
  localparam logic [1:0] SRC_INT_DIV  = 2'h0;
  localparam logic [1:0] SRC_FRAC_BYP = 2'h1;
  localparam logic [1:0] SRC_PATH2    = 2'h3;

  // stop source code that enables register stop control
  localparam logic [3:0] STOP_SRC_REG = 4'h1;

  // pin configuration codes
  localparam logic [3:0] PIN_IN       = 4'h0;
  localparam logic [3:0] PIN_IN_INV   = 4'h1;
  localparam logic [3:0] PIN_OUT_LOW  = 4'h2;
  localparam logic [3:0] PIN_OUT_HIGH = 4'h3;
  localparam logic [3:0] PIN_ST       = 4'h4;
  localparam logic [3:0] PIN_ST_INV   = 4'h5;
  localparam logic [3:0] PIN_ST_OD_0  = 4'h6;
  localparam logic [3:0] PIN_ST_OD_1  = 4'h7;

  // status registers that a pin may not follow (index above status base)
  localparam logic [4:0] ST_IDX_PIN_STATUS = 5'h01;
  localparam logic [4:0] ST_IDX_PLL_IRQ_EN = 5'h0a;

  // output group sources a to f
  typedef struct packed {
    logic [1:0] f;
    logic [1:0] e;
    logic [1:0] d;
    logic [1:0] c;
    logic [1:0] b;
    logic [1:0] a;
  } gcc_src_t;

  // pin drive decision
  typedef struct packed {
    logic drive;
    logic oe_n;
    logic in_value;
  } gcc_pin_t;

endpackage

// ==== core/gcc_pin_drive.sv ====
`timescale 1ns/100ps
`default_nettype none
module gcc_pin_drive (
  input  wire logic [3:0]       cfg_in,     // pin configuration field
  input  wire logic             status_in,  // selected status bit
  input  wire logic             level_in,   // synchronised pin level
  output var gcc_pkg::gcc_pin_t pin_out     // drive, enable, input value
);

  // decode the configuration into drive level, enable and input value
  always_comb
  begin
    pin_out.drive    = 1'b0;
    pin_out.oe_n     = 1'b1;
    pin_out.in_value = 1'b0;
    case (cfg_in)
      gcc_pkg::PIN_IN:       pin_out.in_value = level_in;
      gcc_pkg::PIN_IN_INV:   pin_out.in_value = ~level_in;
      gcc_pkg::PIN_OUT_LOW:  pin_out.oe_n = 1'b0;
      gcc_pkg::PIN_OUT_HIGH:
      begin
        pin_out.oe_n  = 1'b0;
        pin_out.drive = 1'b1;
      end
      gcc_pkg::PIN_ST:
      begin
        pin_out.oe_n  = 1'b0;
        pin_out.drive = status_in;
      end
      gcc_pkg::PIN_ST_INV:
      begin
        pin_out.oe_n  = 1'b0;
        pin_out.drive = ~status_in;
      end
      gcc_pkg::PIN_ST_OD_0:  pin_out.oe_n = status_in;
      gcc_pkg::PIN_ST_OD_1:  pin_out.oe_n = ~status_in;
      default:               pin_out.oe_n = 1'b1;           // unused codes float
    endcase
  end

endmodule
`default_nettype wire

// ==== tb/gcc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// register-port master: moves just after a falling edge, holds over the taking edge
module gcc_host_model (
  input  wire logic       core_clk_in, // register clock
  input  wire logic [7:0] rd_data_in,  // read data from the bank
  output logic      [9:0] addr_out,    // register address
  output logic            wr_en_out,   // write strobe
  output logic      [7:0] wr_data_out, // write data
  output logic            rd_en_out    // read strobe
);
  // idle bus from time zero
  initial
  begin
    addr_out = 10'h000;
    wr_en_out = 1'b0;
    wr_data_out = 8'h00;
    rd_en_out = 1'b0;
  end

  // one write; stale data is inverted so a late sample cannot match by luck
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    addr_out = a;
    wr_data_out = d;
    wr_en_out = 1'b1;
    @(negedge core_clk_in);
    wr_en_out = 1'b0;
    wr_data_out = ~d;
  endtask

  // one read; data is taken one edge after the request
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    addr_out = a;
    rd_en_out = 1'b1;
    @(negedge core_clk_in);
    rd_en_out = 1'b0;
    addr_out = ~a;
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                core_clk = 1'b0;
  logic                srst = 1'b1;
  logic [9:0]          addr;
  logic                wr_en;
  logic [7:0]          wr_data;
  logic                rd_en;
  logic [7:0]          rd_data;
  logic [9:0][3:0]     stop_src = '0;
  logic [3:0][7:0]     psel = '0;
  logic [255:0]        svec = '0;
  logic [255:0]        simpl = '0;
  logic [3:0]          ext = 4'h0;
  logic [3:0]          pin_wire;
  logic [3:0]          drive;
  logic [3:0]          oe_n;
  logic [3:0]          indata;
  logic                xdrv;
  logic                oscen;
  logic                pll_enable_reg;
  logic [2:0]          inen;
  logic [9:0]          outen;
  gcc_pkg::gcc_src_t   gsrc;
  logic [9:0]          stop;
  logic [7:0]          sh [1:12];
  logic [7:0]          d;
  logic [2:0]          e;
  int                  failures = 0;
  int                  n_compared = 0;

  // wire level: the device wins while it drives, else the outside level
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    assign pin_wire[i] = oe_n[i] ? ext[i] : drive[i];
  end

  gcc_regs uut (.core_clk_in(core_clk), .srst_in(srst), .addr_in(addr), .wr_en_in(wr_en),
    .wr_data_in(wr_data), .rd_en_in(rd_en), .rd_data_out(rd_data), .stop_source_in(stop_src),
    .pin_status_select_in(psel), .status_vec_in(svec), .status_impl_in(simpl),
    .pin_level_in(pin_wire), .pin_drive_out(drive), .pin_oe_n_out(oe_n),
    .pin_in_data_out(indata), .xtal_drv_en_out(xdrv), .osc_in_en_out(oscen),
    .pll_enable_out(pll_enable_reg), .input_enable_out(inen), .output_enable_out(outen),
    .group_source_out(gsrc), .output_stop_out(stop));
  gcc_host_model host (.core_clk_in(core_clk), .rd_data_in(rd_data), .addr_out(addr),
    .wr_en_out(wr_en), .wr_data_out(wr_data), .rd_en_out(rd_en));

  // 50 MHz clock
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // implemented bits of each register
  function automatic logic [7:0] mask_of(input int a);
    case (a)
      1: mask_of = gcc_pkg::MASK_MASTER;
      2: mask_of = gcc_pkg::MASK_XTAL_MODE;
      3: mask_of = gcc_pkg::MASK_PLL_EN;
      4: mask_of = gcc_pkg::MASK_IN_EN;
      5: mask_of = gcc_pkg::MASK_OUT_EN_LO;
      6: mask_of = gcc_pkg::MASK_OUT_EN_HI;
      7, 8: mask_of = gcc_pkg::MASK_SRC;
      9: mask_of = gcc_pkg::MASK_STOP_1;
      10: mask_of = gcc_pkg::MASK_STOP_2;
      default: mask_of = gcc_pkg::MASK_PCFG;
    endcase
  endfunction

  // followed status bit; the select byte is reg*8+bit, two registers are never followed
  function automatic logic st_of(input int p);
    if (psel[p][7:3] == 5'h01 || psel[p][7:3] == 5'h0a)
      return 1'b0;
    return svec[psel[p]] & simpl[psel[p]];
  endfunction

  // expected {drive, oe_n, in_data} for a pin code
  function automatic logic [2:0] pin_exp(input int p, input logic [3:0] c);
    case (c)
      4'h0: pin_exp = {1'b0, 1'b1, ext[p]};
      4'h1: pin_exp = {1'b0, 1'b1, ~ext[p]};
      4'h2: pin_exp = 3'b000;
      4'h3: pin_exp = 3'b100;
      4'h4: pin_exp = {st_of(p), 2'b00};
      4'h5: pin_exp = {~st_of(p), 2'b00};
      4'h6: pin_exp = {1'b0, st_of(p), 1'b0};
      4'h7: pin_exp = {1'b0, ~st_of(p), 1'b0};
      default: pin_exp = 3'b010;
    endcase
  endfunction

  // write a register and keep what should read back
  task automatic put(input int a, input logic [7:0] v);
    host.wr(a[9:0], v);
    sh[a] = v & mask_of(a);
  endtask

  task automatic chk_cfg();
    repeat (2) @(negedge core_clk);
    chk("xtal_drv", xdrv, sh[2][1:0] == 2'h1);
    chk("osc_in", oscen, sh[2][1:0] == 2'h1 || sh[2][1:0] == 2'h2);
    chk("pll_en", pll_enable_reg, sh[3][0]);
    chk("in_en", inen, sh[4][2:0]);
    chk("out_en", outen, {sh[6][1:0], sh[5]});
    chk("src", gsrc, {sh[8][5:0], sh[7][5:0]});
    for (int a = 1; a <= 12; a++)
    begin
      host.rd(a[9:0], d);
      chk("readback", d, sh[a]);
    end
  endtask

  initial
  begin
    #400000;
    failures++;
    final_report();
  end

  initial
  begin
    void'($urandom(32'h53c373c1));
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    for (int a = 1; a <= 12; a++)
      sh[a] = 8'h00;
    chk("oe_n rst", oe_n, 4'hf);
    chk_cfg();
    $display("test reset done");
    put(5, 8'had);
    put(6, 8'h01);
    host.wr(10'h020, 8'hff);
    host.rd(10'h020, d);
    chk("unmapped", d, 8'h00);
    put(3, 8'h01);
    chk("pll early", pll_enable_reg, 1'b0);
    @(negedge core_clk);
    chk("pll late", pll_enable_reg, 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      put(2, 8'hfc | m[7:0]);
      chk_cfg();
    end
    for (int r = 0; r < 6; r++)
    begin
      for (int a = 1; a <= 10; a++)
        put(a, 8'($urandom));
      put(7, {2'h3, 2'h3, 2'h1, 2'h0});
      if (r[0])
        put(8, {2'h0, 2'h1, 2'h3, 2'h2});
      chk_cfg();
    end
    $display("test config done");
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    for (int a = 1; a <= 12; a++)
      sh[a] = 8'h00;
    chk("oe_n rst2", oe_n, 4'hf);
    chk_cfg();
    $display("test second reset done");
    for (int r = 0; r < 16; r++)
    begin
      put(1, 8'($urandom));
      put(9, 8'($urandom));
      put(10, 8'($urandom));
      for (int k = 0; k < 10; k++)
        stop_src[k] = $urandom_range(1) ? gcc_pkg::STOP_SRC_REG : 4'($urandom);
      repeat (2) @(negedge core_clk);
      for (int k = 0; k < 10; k++)
        chk("stop", stop[k], stop_src[k] == 4'h1 && ({sh[10][1:0], sh[9]} >> k & 1 || sh[1][5]));
    end
    $display("test stop done");
    for (int c = 0; c < 32; c++)
    begin
      put(11, {4'(c + 1), 4'(c)});
      put(12, {4'(c + 3), 4'(c + 2)});
      svec = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      simpl = {8{$urandom}};
      ext = 4'($urandom);
      for (int p = 0; p < 4; p++)
        psel[p] = (c % 4 == 0) ? {(c[4] ? 5'h01 : 5'h0a), 3'($urandom)} : 8'($urandom);
      repeat (5) @(negedge core_clk);
      for (int p = 0; p < 4; p++)
      begin
        e = pin_exp(p, 4'(c + p));
        chk("pin oe_n", oe_n[p], e[1]);
        chk("pin in", indata[p], e[0]);
        if (!e[1])
          chk("pin drive", drive[p], e[2]);
      end
      host.rd(10'h041, d);
      chk("pin status", d[3:0], pin_wire);
    end
    $display("test pins done");
    final_report();
  end
endmodule
`default_nettype wire
